// *** src/pvc_pkg.sv ***
`default_nettype none
package pvc_pkg;
  typedef enum logic [1:0] {
    PVC_DIV2 = 2'b00,
    PVC_DIV4 = 2'b01,
    PVC_DIV8 = 2'b10,
    PVC_DIV16 = 2'b11
  } pvc_div_type;
  typedef enum logic [1:0] {
    PVC_SYNC_NONE = 2'b00,
    PVC_SYNC_ASYNC = 2'b01,
    PVC_SYNC_SYNC = 2'b10,
    PVC_SYNC_NONE2 = 2'b11
  } pvc_sync_type;
  typedef enum logic {
    PVC_CAL_IDLE = 1'b0,
    PVC_CAL_RUN = 1'b1
  } pvc_cal_state_type;
endpackage : pvc_pkg
`default_nettype wire

// *** src/pvc_regs.svh ***
`ifndef PVC_REGS_SVH
`define PVC_REGS_SVH
// register indices; byte address is four times the index
`define PVC_IDX_CAL 12'h018
`define PVC_IDX_SYNC 12'h019
`define PVC_IDX_UPDATE 12'h01A
`define PVC_IDX_STATUS 12'h01B
// calibration control fields
`define PVC_CAL_TRIG_BIT 0
`define PVC_CAL_DIV_LSB 1
`define PVC_CAL_DIV_MSB 2
`define PVC_CAL_RESET 8'h06
// counter sync and reference delay fields
`define PVC_SYNC_MODE_LSB 6
`define PVC_SYNC_MODE_MSB 7
`define PVC_RDLY_LSB 3
`define PVC_RDLY_MSB 5
`define PVC_SYNC_RESET 8'h00
// update register: writing one here copies staged values into the active set
`define PVC_UPD_BIT 0
// calibration length in calibration clock ticks
`define PVC_CAL_TICKS 64
`endif

// *** src/pvc_top.sv ***
// Behaviour
// - divider field 10 divides the reference clock by 8 to make the calibration clock.
// - divider field 11, the reset value, divides the reference clock by 16.
// - a calibration starts only when the active trigger bit goes from 0 to 1, and the bit resets to 0.
// - counter reset mode 00 and 11 ignore the alignment pin, 01 resets counters asynchronously, 10 synchronously.
// - a three-bit reference path delay field resets to zero and drives the reference path delay.
// - divider field 00 divides by 2 and 01 by 4, both derived from the reference clock.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pvc_regs.svh"
module pvc_top
  import pvc_pkg::*;
#(
  parameter int CAL_TICKS = `PVC_CAL_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_clk_in,
  input wire logic align_n,
  output logic cal_busy,
  output logic cal_clk_en,
  output logic counter_reset_async,
  output logic counter_reset_sync,
  output logic [2:0] ref_path_delay
);

  // the run counter is 16 bits wide, so longer runs cannot be served
  if (CAL_TICKS < 1 || CAL_TICKS > 65535) begin : g_bad_ticks
    $error("pvc_top: CAL_TICKS out of range");
  end

  function automatic logic [3:0] div_last(input pvc_div_type sel);
    unique case (sel)
      PVC_DIV2: div_last = 4'h1;
      PVC_DIV4: div_last = 4'h3;
      PVC_DIV8: div_last = 4'h7;
      PVC_DIV16: div_last = 4'hF;
    endcase
  endfunction : div_last

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] idx);
    hit = (addr[1:0] == 2'b00) && (addr[11:2] == idx[9:0]);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic [7:0] cal_stage_reg;
  logic [7:0] sync_stage_reg;
  logic [7:0] cal_active_reg;
  logic [7:0] sync_active_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  wire sel_cal = hit(paddr, `PVC_IDX_CAL);
  wire sel_sync = hit(paddr, `PVC_IDX_SYNC);
  wire sel_upd = hit(paddr, `PVC_IDX_UPDATE);
  wire sel_stat = hit(paddr, `PVC_IDX_STATUS);
  wire mapped = sel_cal | sel_sync | sel_upd | sel_stat;
  wire setup = psel & ~penable;
  wire wr_done = psel & penable & pwrite & ~pslverr_reg;
  // status is read-only, so a write to it is refused too
  wire bad = ~mapped | (pwrite & sel_stat);
  wire update_strobe = wr_done & sel_upd & pwdata[`PVC_UPD_BIT];

  logic [31:0] rd_mux;
  assign rd_mux = sel_cal ? {24'h00_0000, cal_stage_reg} :
                  sel_sync ? {24'h00_0000, sync_stage_reg} :
                  sel_stat ? {16'h0000, sync_active_reg, 6'h00, cal_busy, cal_active_reg[`PVC_CAL_TRIG_BIT]} :
                  32'h0000_0000;

  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg & psel & penable;

  // read data and error are captured in setup so the access phase answers at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_reg <= bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // staged and active register sets

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_stage_reg <= `PVC_CAL_RESET;
      sync_stage_reg <= `PVC_SYNC_RESET;
    end else if (wr_done) begin
      if (sel_cal) begin
        cal_stage_reg <= pwdata[7:0];
      end
      if (sel_sync) begin
        sync_stage_reg <= pwdata[7:0];
      end
    end
  end

  // settings act only after the update strobe, so a sequence of writes lands together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_active_reg <= `PVC_CAL_RESET;
      sync_active_reg <= `PVC_SYNC_RESET;
    end else if (update_strobe) begin
      cal_active_reg <= cal_stage_reg;
      sync_active_reg <= sync_stage_reg;
    end
  end

  wire pvc_div_type div_sel = pvc_div_type'(cal_active_reg[`PVC_CAL_DIV_MSB:`PVC_CAL_DIV_LSB]);
  wire pvc_sync_type sync_mode = pvc_sync_type'(sync_active_reg[`PVC_SYNC_MODE_MSB:`PVC_SYNC_MODE_LSB]);
  wire trig_now = cal_active_reg[`PVC_CAL_TRIG_BIT];

  assign ref_path_delay = sync_active_reg[`PVC_RDLY_MSB:`PVC_RDLY_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and reference edge

  logic ref_s1_reg;
  logic ref_s2_reg;
  logic ref_s3_reg;
  logic align_s1_reg;
  logic align_s2_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_s1_reg <= 1'b0;
      ref_s2_reg <= 1'b0;
      ref_s3_reg <= 1'b0;
      align_s1_reg <= 1'b1;
      align_s2_reg <= 1'b1;
    end else begin
      ref_s1_reg <= ref_clk_in;
      ref_s2_reg <= ref_s1_reg;
      ref_s3_reg <= ref_s2_reg;
      align_s1_reg <= align_n;
      align_s2_reg <= align_s1_reg;
    end
  end

  // the reference must stay below half of pclk or edges are missed
  wire ref_edge = ref_s2_reg & ~ref_s3_reg;
  wire align_active = ~align_s2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // calibration clock divider

  logic [3:0] div_cnt_reg;
  logic cal_clk_en_reg;
  wire div_wrap = ref_edge && (div_cnt_reg >= div_last(div_sel));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 4'h0;
      cal_clk_en_reg <= 1'b0;
    end else begin
      cal_clk_en_reg <= div_wrap;
      if (div_wrap) begin
        div_cnt_reg <= 4'h0;
      end else if (ref_edge) begin
        div_cnt_reg <= div_cnt_reg + 4'h1;
      end
    end
  end

  assign cal_clk_en = cal_clk_en_reg;

  ////////////////////////////////////////////////////////////////////////////
  // calibration sequencer

  pvc_cal_state_type cal_state_reg;
  logic trig_prev_reg;
  logic [15:0] tick_cnt_reg;
  wire trig_rise = trig_now & ~trig_prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_state_reg <= PVC_CAL_IDLE;
      trig_prev_reg <= 1'b0;
      tick_cnt_reg <= 16'h0000;
    end else begin
      trig_prev_reg <= trig_now;
      unique case (cal_state_reg)
        PVC_CAL_IDLE: begin
          if (trig_rise) begin
            cal_state_reg <= PVC_CAL_RUN;
            tick_cnt_reg <= 16'(CAL_TICKS);
          end
        end
        PVC_CAL_RUN: begin
          // a rise while running is not queued; the host restarts with a fresh 0 then 1
          if (cal_clk_en_reg) begin
            tick_cnt_reg <= tick_cnt_reg - 16'h0001;
            if (tick_cnt_reg == 16'h0001) begin
              cal_state_reg <= PVC_CAL_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign cal_busy = (cal_state_reg == PVC_CAL_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // counter reset from the alignment pin

  logic sync_rst_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_rst_reg <= 1'b0;
    end else if (ref_edge) begin
      sync_rst_reg <= align_active && (sync_mode == PVC_SYNC_SYNC);
    end
  end

  // async mode follows the synchronised pin level directly, with no reference alignment
  assign counter_reset_async = align_active && (sync_mode == PVC_SYNC_ASYNC);
  assign counter_reset_sync = sync_rst_reg;

endmodule : pvc_top
`default_nettype wire

// *** testbench/pvc_ref_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module pvc_ref_src (
  input wire logic run,
  input wire logic align_req,
  output logic ref_clk_in,
  output logic align_n
);
  // edges sit 1 ns off the pclk grid so sampling never races; held low when stopped
  initial begin
    ref_clk_in = 1'b0;
    #1;
    forever #8 ref_clk_in = run & ~ref_clk_in;
  end
  assign align_n = ~align_req;
endmodule : pvc_ref_src
`default_nettype wire

// *** testbench/pvc_top_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pvc_regs.svh"
module pvc_top_chk #(
  parameter int CAL_TICKS = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire logic align_n,
  input wire logic ref_clk_in,
  input wire logic cal_busy,
  input wire logic cal_clk_en,
  input wire logic counter_reset_async,
  input wire logic counter_reset_sync,
  input wire logic [2:0] ref_path_delay
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  int tick_cnt;
  // only pulses inside a run count, so a free-running divider cannot confuse it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 0;
    end else begin
      tick_cnt <= cal_busy ? tick_cnt + int'(cal_clk_en) : 0;
    end
  end
  sequence ref_quiet;
    $stable(ref_clk_in) [*5];
  endsequence
  chk_err_phase: assert property (pslverr |-> psel && penable) else $error("err outside access");
  chk_err_unmapped: assert property (psel && penable && (paddr[1:0] != 2'b00 || paddr[11:2] < 10'(`PVC_IDX_CAL) ||
    paddr[11:2] > 10'(`PVC_IDX_STATUS)) |-> pslverr) else $error("unmapped access not refused");
  chk_busy_start: assert property ($rose(cal_busy) |-> $past(psel && penable && pwrite, 2))
    else $error("busy without update");
  chk_busy_len: assert property ($fell(cal_busy) |-> tick_cnt == CAL_TICKS && $past(cal_clk_en))
    else $error("run length");
  chk_tick_gap: assert property (cal_clk_en |=> !cal_clk_en [*3]) else $error("tick gap");
  chk_async_mode: assert property (counter_reset_async |-> !$past(align_n, 2) && !counter_reset_sync)
    else $error("async reset");
  chk_sync_edge: assert property (ref_quiet |=> $stable(counter_reset_sync)) else $error("sync reset");
  chk_rdly_write: assert property ($changed(ref_path_delay) |-> $past(psel && penable && pwrite))
    else $error("delay change");
  chk_rdly_reset: assert property ($rose(presetn) |-> ref_path_delay == 3'h0) else $error("delay reset");
endmodule : pvc_top_chk
bind pvc_top pvc_top_chk #(.CAL_TICKS(CAL_TICKS)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pslverr,
  .paddr, .align_n, .ref_clk_in, .cal_busy, .cal_clk_en, .counter_reset_async, .counter_reset_sync,
  .ref_path_delay);
`default_nettype wire

// *** testbench/tb_pll_vco_cal_and_counter_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pvc_regs.svh"
module tb_pll_vco_cal_and_counter_sync;
  localparam logic [11:0] A_CAL = `PVC_IDX_CAL << 2;
  localparam logic [11:0] A_SYNC = `PVC_IDX_SYNC << 2;
  localparam logic [11:0] A_UPD = `PVC_IDX_UPDATE << 2;
  localparam logic [11:0] A_STAT = `PVC_IDX_STATUS << 2;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ref_clk_in, align_n, err;
  logic cal_busy, cal_clk_en, counter_reset_async, counter_reset_sync, ref_run, align_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] ref_path_delay;
  int error_cnt = 0;
  int checked = 0;
  int c;
  pvc_top #(.CAL_TICKS(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ref_clk_in, .align_n, .cal_busy, .cal_clk_en, .counter_reset_async, .counter_reset_sync,
    .ref_path_delay);
  pvc_ref_src host (.run(ref_run), .align_req, .ref_clk_in, .align_n);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic gap();
    while (cal_clk_en !== 1'b1) @(negedge pclk);
    c = 0;
    do begin
      @(negedge pclk);
      c++;
    end while (cal_clk_en !== 1'b1);
  endtask : gap
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    {psel, penable, pwrite, align_req, presetn} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    ref_run = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_CAL, 32'h0);
    check(rd, 32'h6);
    apb(1'b0, A_SYNC, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h070, 32'h0);
    check({rd[31:1], err}, 32'h1);
    apb(1'b1, A_STAT, 32'hff);
    check(err, 1'b1);
    apb(1'b0, A_UPD, 32'h0);
    check({rd[31:1], err}, 32'h0);
    check(pready, 1'b1);
    $display("reset test done");
    // the output divider lives outside this block and is never parked here
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, A_CAL, 32'(d << 1));
      apb(1'b1, A_UPD, 32'h1);
      apb(1'b1, A_CAL, 32'(d << 1 | 1));
      apb(1'b1, A_UPD, 32'h1);
      repeat (3) @(negedge pclk);
      check(cal_busy, 1'b1);
      apb(1'b0, A_STAT, 32'h0);
      check(rd, 32'h3);
      gap();
      gap();
      check(c, 32'(8 << d));
      while (cal_busy) @(negedge pclk);
    end
    apb(1'b1, A_UPD, 32'h1);
    repeat (3) @(negedge pclk);
    check(cal_busy, 1'b0);
    $display("calibration test done");
    apb(1'b1, A_SYNC, 32'h28);
    check(ref_path_delay, 3'h0);
    apb(1'b1, A_UPD, 32'h1);
    @(negedge pclk);
    check(ref_path_delay, 3'h5);
    apb(1'b0, A_STAT, 32'h0);
    check(rd, 32'h2801);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, A_SYNC, 32'(m << 6));
      apb(1'b1, A_UPD, 32'h1);
      ref_run <= (m != 2);
      align_req <= 1'b1;
      repeat (20) @(negedge pclk);
      check({counter_reset_async, counter_reset_sync}, m == 1 ? 2'b10 : 2'b00);
      @(posedge pclk);
      ref_run <= 1'b1;
      repeat (20) @(negedge pclk);
      check({counter_reset_async, counter_reset_sync}, m == 1 ? 2'b10 : {1'b0, m == 2});
      @(posedge pclk);
      align_req <= 1'b0;
    end
    $display("counter reset test done");
    apb(1'b1, A_SYNC, 32'h28);
    apb(1'b1, A_CAL, 32'h6);
    apb(1'b1, A_UPD, 32'h1);
    apb(1'b1, A_CAL, 32'h7);
    apb(1'b1, A_UPD, 32'h1);
    repeat (3) @(negedge pclk);
    check(cal_busy, 1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check({cal_busy, ref_path_delay}, 4'h0);
    apb(1'b0, A_STAT, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, A_CAL, 32'h0);
    check(rd, 32'h6);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule : tb_pll_vco_cal_and_counter_sync
`default_nettype wire
